/* File: rx_cfg_pkg.sv */
// Purpose: Constants and types for the receiver configuration register bank
// Assumes: AXI4-Lite slave at 32-bit data, 40 MHz bus clock
// Notes: Offsets are byte addresses within the block
// Operation
// - Every configuration register is read and written over the AXI4-Lite slave, synchronous to its clock.
// - A single-bit status that changes during a read returns either the old or the new value.
// - A lock bit freezes a multi-bit status field so that a read of it is coherent.
// - After writing multi-bit configuration the host flips a toggle bit and the device copies it to the core.
// - Undefined register bits are reserved and read as zero.
// - Every register clears to zero at reset unless defined otherwise.
// - Writing 1 to the run control register enables the receiver and drives hot plug detect high.
// - A 1 MHz timebase is made by integer division of the bus clock by divider bits 7:0.
// - Divider bits 27:24 hold a defer count of 0 to 8 replied to lane 0/1 status reads.
// - Divider bits 15:8 hold the pulse filter width in bus clocks, 0 to 48 in steps of 8.
// - Each bit of the line reset inhibit register suppresses end-of-line reset for one stream.
// - Bit 0 of the timing generator register enables the frame timing generator.
package rx_cfg_pkg;
    localparam int ADDR_W = 14;
    localparam logic [13:0] OFF_RUN = 14'h000;
    localparam logic [13:0] OFF_DIV = 14'h004;
    localparam logic [13:0] OFF_LRI = 14'h008;
    localparam logic [13:0] OFF_TGEN = 14'h00c;
    localparam logic [13:0] OFF_STAT = 14'h0f0;
    localparam logic [13:0] OFF_CTRL = 14'h0f4;
    localparam int DIV_LSB = 0;
    localparam int FILT_LSB = 8;
    localparam int DEFER_LSB = 24;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_TOGGLE_BIT = 1;
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [3:0] DEFER_MAX = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] defer_count;
        logic [7:0] filter_width;
        logic [7:0] divider;
    } aux_cfg_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rd_state_t;
endpackage : rx_cfg_pkg

/* File: aux_timebase.sv */
// Purpose: Integer divider giving a one-cycle timebase enable pulse
// Assumes: Divide value is stable between updates
// Notes: A divide value of zero stops the pulse
`timescale 1ns/1ps
module aux_timebase (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] divide,
    output logic tick
);
    logic [7:0] count_q;

    // Integer division only; fractional bus clock rates cannot be matched
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 8'h00;
            tick <= 1'b0;
        end
        else if (divide == 8'h00)
        begin
            count_q <= 8'h00;
            tick <= 1'b0;
        end
        else if (count_q >= divide - 8'h01)
        begin
            count_q <= 8'h00;
            tick <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule : aux_timebase

/* File: rx_core_config_regs.sv */
// Purpose: Receiver core configuration registers behind an AXI4-Lite slave
// Assumes: One bus clock; status inputs arrive from other domains
// Notes: Core-side divider fields change only on a toggle flip; line reset inhibit follows its register directly
`timescale 1ns/1ps
module rx_core_config_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic no_video_det,
    input wire logic [7:0] lane_status,
    output logic hpd,
    output logic core_enable,
    output logic aux_tick,
    output rx_cfg_pkg::aux_cfg_t aux_cfg,
    output logic cfg_update_toggle,
    output logic [3:0] line_reset_inhibit,
    output logic timing_generator_on
);
    logic [31:0] run_q;
    logic [31:0] div_q;
    logic [3:0] lri_q;
    logic tgen_q;
    logic [1:0] ctrl_q;
    logic toggle_seen_q;
    logic [2:0] nv_sync_q;
    logic no_video_q;
    logic [7:0] ls_s1_q;
    logic [7:0] ls_s2_q;
    logic [7:0] ls_s3_q;
    logic [7:0] lane_hold_q;
    logic wr_go;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_hit;
    rx_cfg_pkg::rd_state_t rd_state_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    function automatic logic [3:0] clamp_defer(input logic [3:0] v);
        clamp_defer = (v > rx_cfg_pkg::DEFER_MAX) ? rx_cfg_pkg::DEFER_MAX : v;
    endfunction : clamp_defer

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken together, one at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_mask
            assign wmask[g*8 +: 8] = {8{s_axi_wstrb[g]}};
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rx_cfg_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                case (s_axi_awaddr & 14'h3ffc)
                    rx_cfg_pkg::OFF_RUN, rx_cfg_pkg::OFF_DIV, rx_cfg_pkg::OFF_LRI,
                    rx_cfg_pkg::OFF_TGEN, rx_cfg_pkg::OFF_STAT, rx_cfg_pkg::OFF_CTRL:
                        s_axi_bresp <= rx_cfg_pkg::RESP_OKAY;
                    default:
                        s_axi_bresp <= rx_cfg_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage, all cleared at reset
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_q <= rx_cfg_pkg::RST_REG;
            div_q <= rx_cfg_pkg::RST_REG;
            lri_q <= 4'h0;
            tgen_q <= 1'b0;
            ctrl_q <= 2'h0;
        end
        else if (wr_go)
        begin
            case (s_axi_awaddr & 14'h3ffc)
                rx_cfg_pkg::OFF_RUN:
                    run_q <= merge(run_q, s_axi_wdata, wmask & 32'h0000_0001);
                rx_cfg_pkg::OFF_DIV:
                    div_q <= merge(div_q, s_axi_wdata, wmask & 32'h0f00_ffff);
                rx_cfg_pkg::OFF_LRI:
                    lri_q <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : lri_q;
                rx_cfg_pkg::OFF_TGEN:
                    tgen_q <= s_axi_wstrb[0] ? s_axi_wdata[0] : tgen_q;
                rx_cfg_pkg::OFF_CTRL:
                    ctrl_q <= s_axi_wstrb[0] ? s_axi_wdata[1:0] : ctrl_q;
                default:
                    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status inputs from other domains, three stages, change when 2nd and 3rd agree
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nv_sync_q <= 3'h0;
            no_video_q <= 1'b0;
            ls_s1_q <= 8'h00;
            ls_s2_q <= 8'h00;
            ls_s3_q <= 8'h00;
            lane_hold_q <= 8'h00;
        end
        else
        begin
            nv_sync_q <= {nv_sync_q[1:0], no_video_det};
            if (nv_sync_q[1] == nv_sync_q[2])
            begin
                no_video_q <= nv_sync_q[2];
            end
            ls_s1_q <= lane_status;
            ls_s2_q <= ls_s1_q;
            ls_s3_q <= ls_s2_q;
            // Frozen while locked so a read returns one coherent sample
            if (!ctrl_q[rx_cfg_pkg::CTRL_LOCK_BIT] && ls_s2_q == ls_s3_q)
            begin
                lane_hold_q <= ls_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr & 14'h3ffc)
            rx_cfg_pkg::OFF_RUN: rd_word = {31'h0, run_q[0]};
            rx_cfg_pkg::OFF_DIV: rd_word = div_q;
            rx_cfg_pkg::OFF_LRI: rd_word = {28'h0, lri_q};
            rx_cfg_pkg::OFF_TGEN: rd_word = {31'h0, tgen_q};
            rx_cfg_pkg::OFF_STAT: rd_word = {16'h0, lane_hold_q, 7'h0, no_video_q};
            rx_cfg_pkg::OFF_CTRL: rd_word = {30'h0, ctrl_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_state_q <= rx_cfg_pkg::RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rx_cfg_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            case (rd_state_q)
                rx_cfg_pkg::RD_IDLE:
                    if (s_axi_arvalid)
                    begin
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= rd_word;
                        s_axi_rresp <= rd_hit ? rx_cfg_pkg::RESP_OKAY : rx_cfg_pkg::RESP_SLVERR;
                        rd_state_q <= rx_cfg_pkg::RD_RESP;
                    end
                rx_cfg_pkg::RD_RESP:
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        rd_state_q <= rx_cfg_pkg::RD_IDLE;
                    end
                default:
                    rd_state_q <= rx_cfg_pkg::RD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core-facing copies; multi-bit values move only on a toggle flip
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            toggle_seen_q <= 1'b0;
            aux_cfg <= '0;
            cfg_update_toggle <= 1'b0;
        end
        else if (ctrl_q[rx_cfg_pkg::CTRL_TOGGLE_BIT] != toggle_seen_q)
        begin
            toggle_seen_q <= ctrl_q[rx_cfg_pkg::CTRL_TOGGLE_BIT];
            aux_cfg.divider <= div_q[rx_cfg_pkg::DIV_LSB +: 8];
            aux_cfg.filter_width <= div_q[rx_cfg_pkg::FILT_LSB +: 8];
            aux_cfg.defer_count <= clamp_defer(div_q[rx_cfg_pkg::DEFER_LSB +: 4]);
            // Flipped in the same cycle as the copy; far side syncs this level then samples
            cfg_update_toggle <= ~cfg_update_toggle;
        end
    end

    // Run, line reset inhibit and timing outputs, each a flop
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hpd <= 1'b0;
            core_enable <= 1'b0;
            line_reset_inhibit <= 4'h0;
            timing_generator_on <= 1'b0;
        end
        else
        begin
            hpd <= run_q[0];
            core_enable <= run_q[0];
            line_reset_inhibit <= lri_q;
            timing_generator_on <= tgen_q;
        end
    end

    aux_timebase u_timebase (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .divide(aux_cfg.divider),
        .tick(aux_tick)
    );
endmodule : rx_core_config_regs

/* File: rx_core_config_regs_chk.sv */
// Purpose: Port-level checks for the configuration register bank
// Assumes: One bus clock, asynchronous active-low reset
// Notes: Watches a subset of the top ports only
`timescale 1ns/1ps
module rx_core_config_regs_chk (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hpd,
    input wire logic core_enable,
    input wire logic aux_tick,
    input wire rx_cfg_pkg::aux_cfg_t aux_cfg,
    input wire logic cfg_update_toggle
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
        |=> s_axi_awready && s_axi_bvalid) else $error("write not answered");
    wready_pair_a: assert property (s_axi_wready == s_axi_awready)
        else $error("write data ready apart from address ready");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
    rd_answer_a: assert property (
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved while waiting");
    slverr_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == rx_cfg_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    hpd_enable_a: assert property (hpd == core_enable)
        else $error("hot plug and enable differ");
    cfg_toggle_a: assert property (
        $changed(aux_cfg) |-> $changed(cfg_update_toggle)) else $error("core copy moved alone");
    defer_clamp_a: assert property (
        aux_cfg.defer_count <= rx_cfg_pkg::DEFER_MAX) else $error("defer count above limit");
    tick_stop_a: assert property (
        aux_cfg.divider == 8'h00 && $past(aux_cfg.divider) == 8'h00 |-> !aux_tick)
        else $error("tick with divider zero");
    tick_gap_a: assert property (
        aux_tick && aux_cfg.divider > 8'h01 |=> !aux_tick || $changed(aux_cfg))
        else $error("ticks too close");
endmodule : rx_core_config_regs_chk

/* File: cfg_bus_host.sv */
// Purpose: Register bus master standing in for the host processor
// Assumes: Drives one edge plus 1 ns, samples on rising edges
// Notes: ready_delay stalls the response phase to hold answers
`timescale 1ns/1ps
module cfg_bus_host (
    input wire logic sys_clk,
    output logic [13:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic [1:0] s_axi_bresp,
    output logic s_axi_bready,
    output logic [13:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    output logic s_axi_rready
);
    int ready_delay = 0;
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    ////////////////////////////////////////
    // Address and data are inverted on release so stale values never look valid
    task automatic xfer(input logic rd, input logic [13:0] addr, input logic [31:0] data,
                        output logic [31:0] rdat, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        s_axi_awaddr = addr;
        s_axi_araddr = addr;
        s_axi_wdata = data;
        s_axi_wstrb = 4'hf;
        {s_axi_arvalid, s_axi_awvalid, s_axi_wvalid} = {rd, !rd, !rd};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while ((rd ? s_axi_arready : s_axi_awready) !== 1'b1 && n < 16);
        #1;
        {s_axi_arvalid, s_axi_awvalid, s_axi_wvalid} = 3'b000;
        s_axi_awaddr = ~addr;
        s_axi_araddr = ~addr;
        s_axi_wdata = ~data;
        // A slow host lets edges pass first, then drives 1 ns after an edge as usual
        if (ready_delay > 0)
        begin
            repeat (ready_delay) @(posedge sys_clk);
            #1;
        end
        {s_axi_bready, s_axi_rready} = {!rd, rd};
        @(posedge sys_clk);
        rdat = s_axi_rdata;
        resp = rd ? s_axi_rresp : s_axi_bresp;
        #1;
        {s_axi_bready, s_axi_rready} = 2'b00;
    endtask : xfer
endmodule : cfg_bus_host

/* File: test_rx_core_config_regs.sv */
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Host model makes every bus access
// Notes: Table rows cover plain accesses, hand tests follow
`timescale 1ns/1ps
module test_rx_core_config_regs;
    logic sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic no_video_det, hpd, core_enable, aux_tick, cfg_update_toggle, timing_generator_on;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, line_reset_inhibit;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] lane_status;
    rx_cfg_pkg::aux_cfg_t aux_cfg;
    int n_errors = 0, n_compared = 0, ticks;
    logic [79:0] rows [5] = '{
        {14'h000, 32'hffff_ffff, 32'h0000_0001, 2'h0},
        {14'h004, 32'hffff_ffff, 32'h0f00_ffff, 2'h0},
        {14'h008, 32'hffff_ffff, 32'h0000_000f, 2'h0},
        {14'h00c, 32'hffff_ffff, 32'h0000_0001, 2'h0},
        {14'h010, 32'hffff_ffff, 32'h0000_0000, 2'h2}};
    rx_core_config_regs dut (.*);
    cfg_bus_host host (.*);
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [13:0] a, input logic [31:0] v);
        host.xfer(1'b0, a, v, d, r);
    endtask : wr
    task automatic rd(input logic [13:0] a);
        host.xfer(1'b1, a, 32'h0, d, r);
    endtask : rd
    task automatic results;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        n_errors++;
        results();
    end
    initial
    begin
        reset_n = 1'b0;
        no_video_det = 1'b0;
        lane_status = 8'h00;
        repeat (6) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        foreach (rows[i])
        begin
            wr(rows[i][79:66], rows[i][65:34]);
            check(r, rows[i][1:0]);
            rd(rows[i][79:66]);
            check(d, rows[i][33:2]);
            check(r, rows[i][1:0]);
        end
        check({hpd, core_enable, timing_generator_on, line_reset_inhibit}, 32'h7f);
        check(aux_cfg, 32'h0);
        wr(14'h004, 32'h0300_1805);
        wr(14'h0f4, 32'h2);
        repeat (4) @(posedge sys_clk);
        check({cfg_update_toggle, aux_cfg}, 32'h13_1805);
        ticks = 0;
        repeat (100)
        begin
            @(posedge sys_clk);
            ticks += aux_tick;
        end
        check(ticks, 32'd20);
        // Slow host holds every answer for three extra cycles
        host.ready_delay = 3;
        wr(14'h004, 32'h0f00_0005);
        wr(14'h0f4, 32'h0);
        rd(14'h004);
        check(d, 32'h0f00_0005);
        check(aux_cfg.defer_count, 32'h8);
        no_video_det = 1'b1;
        lane_status = 8'ha5;
        repeat (8) @(posedge sys_clk);
        #1;
        wr(14'h0f4, 32'h1);
        lane_status = 8'h5a;
        // Long enough for the new sample to pass the synchroniser if the lock failed
        repeat (8) @(posedge sys_clk);
        rd(14'h0f0);
        check(d, 32'h0000_a501);
        if (d[0])
            wr(14'h00c, 32'h0);
        check(timing_generator_on, 32'h0);
        wr(14'h000, 32'h0);
        check(hpd, 32'h0);
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        foreach (rows[i])
        begin
            rd(rows[i][79:66]);
            check(d, 32'h0);
        end
        check({hpd, cfg_update_toggle, line_reset_inhibit, aux_cfg}, 32'h0);
        results();
    end
endmodule : test_rx_core_config_regs

bind rx_core_config_regs rx_core_config_regs_chk chk (.*);
